// >>> rtl/two_level_vectored_irq_unit.sv
`timescale 1ns/100ps
`default_nettype none

`include "irq_unit_params.svh"

// Summary of operation
// - Flags are sampled and arbitration redone every system clock.
// - Best response: one detect, one instruction, five-clock long call.
// - Pending at return: one more instruction completes before the call.
// - Worst response nineteen clocks: detect, return, divide, long call.
// - Equal or higher active routine holds new requests until its return.
// - Reset vector 0x0000; seventeen sources at 0x0003 plus eight per index.
// - Vectoring clears only external 0/1 and timer 0/1 flags.
// - Global gate bit 7 overrides all masks.
// - Enable bits six to zero mask the seven basic sources.
// - Timer 2 mask gates both timer 2 overflow flags.
// - Priority bit 7 reads one, writes ignored.
// - Priority bits six to zero pick level per basic source.
// - External masks gate requests from active-low pins.
// - Flags set regardless of masks; stay pending while gated.
// - High preempts low; high never preempted; level then index.
// - Flag still set after return raises a new request at once.
module two_level_vectored_irq_unit
    import irq_unit_pkg::*;
#(
    parameter int NUM_EXT = `IRQ_NUM_EXTENDED
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    output logic [7:0] sfr_rdata,
    input wire logic ext_irq_pin_zero_n,
    input wire logic ext_irq_pin_one_n,
    input wire logic [1:0] ext_flag_sw_set,
    input wire logic [1:0] ext_flag_sw_clr,
    output logic [1:0] ext_flag,
    input wire logic timer_zero_flag,
    input wire logic timer_one_flag,
    output logic timer_zero_clr,
    output logic timer_one_clr,
    input wire logic uart_rx_flag,
    input wire logic uart_tx_flag,
    input wire logic timer_two_low_overflow,
    input wire logic timer_two_high_overflow,
    input wire logic [3:0] serial_periph_flags,
    input wire logic [NUM_EXT-1:0] ext_src_flags,
    input wire logic [NUM_EXT-1:0] ext_src_enable,
    input wire logic [NUM_EXT-1:0] ext_src_level,
    input wire logic insn_done,
    input wire logic return_from_interrupt_done,
    input wire logic call_ack,
    output logic call_req,
    output logic [15:0] call_vector,
    output logic call_level,
    output logic [4:0] call_index
);

    localparam int NSRC = `IRQ_NUM_BASIC + NUM_EXT;

    irq_state_t st_reg;
    irq_state_t st_next;

    // ==========================================================
    // Request vector, masks and levels
    logic [NSRC-1:0] src_req;
    logic [NSRC-1:0] src_gate;
    logic [NSRC-1:0] src_lvl;
    logic act_hi_next;
    logic act_lo_next;
    logic pick_valid;
    logic [4:0] pick_idx;
    logic pick_lvl;

    assign src_req = {ext_src_flags,
                      |serial_periph_flags,
                      timer_two_low_overflow | timer_two_high_overflow,
                      uart_rx_flag | uart_tx_flag,
                      timer_one_flag,
                      st_reg.ext_flag[1],
                      timer_zero_flag,
                      st_reg.ext_flag[0]};
    // Global gate over individual masks
    assign src_gate = {ext_src_enable, st_reg.enable[6:0]}
                      & {NSRC{st_reg.enable[`GLOBAL_IRQ_GATE_BIT]}};
    assign src_lvl = {ext_src_level, st_reg.level};

    // Active-level stack: call pushes, return pops the top level
    always_comb begin
        act_hi_next = st_reg.active_hi;
        act_lo_next = st_reg.active_lo;
        if (call_ack) begin
            act_hi_next = st_reg.active_hi | st_reg.call_lvl;
            act_lo_next = st_reg.active_lo | ~st_reg.call_lvl;
        end else if (return_from_interrupt_done) begin
            if (st_reg.active_hi) begin
                act_hi_next = 1'b0;
            end else begin
                act_lo_next = 1'b0;
            end
        end
    end

    irq_prio_pick #(
        .N(NSRC)
    ) u_pick (
        .req(src_req & src_gate),
        .lvl(src_lvl),
        .active_hi(act_hi_next),
        .active_lo(act_lo_next),
        .valid(pick_valid),
        .idx(pick_idx),
        .pick_lvl(pick_lvl)
    );

    // ==========================================================
    // Next-state logic
    logic [1:0] pin_fall;
    logic [1:0] ext_hw_clr;

    assign pin_fall = st_reg.pin_prev & ~st_reg.sync2;
    assign ext_hw_clr = {call_ack && st_reg.call_idx == `IRQ_SRC_EXT_ONE,
                         call_ack && st_reg.call_idx == `IRQ_SRC_EXT_ZERO};

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = {ext_irq_pin_one_n, ext_irq_pin_zero_n};
        st_next.sync2 = st_reg.sync1;
        st_next.pin_prev = st_reg.sync2;
        // Set wins over any clear in the same cycle
        st_next.ext_flag = (st_reg.ext_flag & ~(ext_hw_clr | ext_flag_sw_clr))
                           | pin_fall | ext_flag_sw_set;
        if (sfr_wr && sfr_addr == `IRQ_ENABLE_BASIC_ADDR) begin
            st_next.enable = sfr_wdata;
        end
        if (sfr_bit_wr && sfr_addr == `IRQ_ENABLE_BASIC_ADDR) begin
            st_next.enable[sfr_bit_sel] = sfr_bit_val;
        end
        if (sfr_wr && sfr_addr == `IRQ_PRIORITY_BASIC_ADDR) begin
            st_next.level = sfr_wdata[6:0];
        end
        if (sfr_bit_wr && sfr_addr == `IRQ_PRIORITY_BASIC_ADDR
            && sfr_bit_sel != 3'(`PRIORITY_UNUSED_BIT)) begin
            st_next.level[sfr_bit_sel] = sfr_bit_val;
        end
        case (sfr_addr)
            `IRQ_ENABLE_BASIC_ADDR: st_next.rdata = st_reg.enable;
            `IRQ_PRIORITY_BASIC_ADDR: begin
                st_next.rdata = {1'b1, st_reg.level};
            end
            default: st_next.rdata = 8'h00;
        endcase
        st_next.active_hi = act_hi_next;
        st_next.active_lo = act_lo_next;
        // Decoded in the sampling cycle, presented the next clock
        st_next.call_req = pick_valid;
        if (pick_valid) begin
            st_next.call_idx = pick_idx;
            st_next.call_lvl = pick_lvl;
            st_next.call_vec = `IRQ_VECTOR_BASE
                               + {8'h00, pick_idx, 3'b000};
        end
        st_next.tmr_clr[1] = call_ack
                             && st_reg.call_idx == `IRQ_SRC_TIMER_ONE;
        st_next.tmr_clr[0] = call_ack
                             && st_reg.call_idx == `IRQ_SRC_TIMER_ZERO;
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg.sync1 <= 2'h3;
            st_reg.sync2 <= 2'h3;
            st_reg.pin_prev <= 2'h3;
            st_reg.ext_flag <= 2'h0;
            st_reg.enable <= `IRQ_ENABLE_BASIC_RST;
            st_reg.level <= 7'(`IRQ_PRIORITY_BASIC_RST);
            st_reg.active_hi <= 1'b0;
            st_reg.active_lo <= 1'b0;
            st_reg.call_req <= 1'b0;
            st_reg.call_lvl <= 1'b0;
            st_reg.call_idx <= 5'h00;
            st_reg.call_vec <= `IRQ_RESET_VECTOR;
            st_reg.tmr_clr <= 2'h0;
            st_reg.rdata <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata = st_reg.rdata;
    assign ext_flag = st_reg.ext_flag;
    assign timer_zero_clr = st_reg.tmr_clr[0];
    assign timer_one_clr = st_reg.tmr_clr[1];
    assign call_req = st_reg.call_req;
    assign call_vector = st_reg.call_vec;
    assign call_level = st_reg.call_lvl;
    assign call_index = st_reg.call_idx;

    // ==========================================================
    // Checks
    AST_SAMPLE_ONE_CLOCK: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (st_reg.enable[7] && st_reg.enable[1] && timer_zero_flag
         && !st_reg.active_hi && !st_reg.active_lo && !call_ack && !return_from_interrupt_done)
        |=> call_req)
        else $error("Enabled request not presented after one clock");

    AST_GLOBAL_GATE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !st_reg.enable[7] |=> !call_req)
        else $error("Request raised while globally gated");

    AST_HIGH_NOT_PREEMPTED: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (st_reg.active_hi && !return_from_interrupt_done) |=> !call_req)
        else $error("High-level routine preempted");

    AST_LOW_ONLY_BY_HIGH: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (st_reg.active_lo && !return_from_interrupt_done && !call_ack)
        |=> (!call_req || call_level))
        else $error("Equal level request taken during low routine");

    AST_VECTOR_MAP: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        call_req |-> (call_vector == 16'h0003 + {8'h00, call_index, 3'b000}
                      && call_vector <= 16'h0083))
        else $error("Vector does not match source index");

    AST_TIMER_CLEAR: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (call_ack && call_index == 5'h01)
        |=> (timer_zero_clr && !timer_one_clr) ##1 !timer_zero_clr)
        else $error("Timer 0 flag not cleared on vectoring");

    AST_NO_SOFT_CLEAR: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (call_ack && call_index > 5'h03)
        |=> (!timer_zero_clr && !timer_one_clr))
        else $error("Hardware cleared a software-cleared flag");

    AST_PIN_SETS_FLAG: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $fell(st_reg.sync2[0]) |=> ext_flag[0])
        else $error("Pin edge did not set external flag");

    AST_PRIORITY_TOP_READ: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $past(sfr_addr) == `IRQ_PRIORITY_BASIC_ADDR |-> sfr_rdata[7])
        else $error("Priority top bit not read as one");

endmodule : two_level_vectored_irq_unit

`default_nettype wire

// >>> rtl/irq_unit_params.svh
`ifndef IRQ_UNIT_PARAMS_SVH
`define IRQ_UNIT_PARAMS_SVH

// ==========================================================
// Register addresses and reset values
`define IRQ_ENABLE_BASIC_ADDR 8'ha8
`define IRQ_PRIORITY_BASIC_ADDR 8'hb8
`define IRQ_ENABLE_BASIC_RST 8'h00
`define IRQ_PRIORITY_BASIC_RST 8'h80

// ==========================================================
// Field positions
`define GLOBAL_IRQ_GATE_BIT 7
`define PRIORITY_UNUSED_BIT 7

// ==========================================================
// Sources and vectors
`define IRQ_NUM_SOURCES 17
`define IRQ_NUM_BASIC 7
`define IRQ_NUM_EXTENDED 10
`define IRQ_SRC_EXT_ZERO 5'h00
`define IRQ_SRC_TIMER_ZERO 5'h01
`define IRQ_SRC_EXT_ONE 5'h02
`define IRQ_SRC_TIMER_ONE 5'h03
`define IRQ_RESET_VECTOR 16'h0000
`define IRQ_VECTOR_BASE 16'h0003
`define IRQ_VECTOR_LAST 16'h0083

// ==========================================================
// Response timing in system clocks
`define IRQ_DETECT_CYCLES 1
`define IRQ_LONG_CALL_CYCLES 5
`define IRQ_BEST_RESPONSE_CYCLES 7
`define IRQ_WORST_RESPONSE_CYCLES 19
`define IRQ_DIVIDE_CYCLES 8

`endif

// >>> rtl/irq_unit_pkg.sv
`include "irq_unit_params.svh"

package irq_unit_pkg;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] pin_prev;
        logic [1:0] ext_flag;
        logic [7:0] enable;
        logic [6:0] level;
        logic active_hi;
        logic active_lo;
        logic call_req;
        logic call_lvl;
        logic [4:0] call_idx;
        logic [15:0] call_vec;
        logic [1:0] tmr_clr;
        logic [7:0] rdata;
    } irq_state_t;

endpackage : irq_unit_pkg

// >>> rtl/irq_prio_pick.sv
`timescale 1ns/100ps
`default_nettype none

module irq_prio_pick #(
    parameter int N = 17
) (
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] lvl,
    input wire logic active_hi,
    input wire logic active_lo,
    output logic valid,
    output logic [4:0] idx,
    output logic pick_lvl
);

    // Lowest index wins inside one level
    function automatic logic [4:0] lowest(input logic [N-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : lowest

    logic [N-1:0] hi_req;
    logic [N-1:0] lo_req;

    assign hi_req = req & lvl;
    assign lo_req = req & ~lvl;

    always_comb begin
        valid = 1'b0;
        idx = 5'h00;
        pick_lvl = 1'b0;
        if ((|hi_req) && !active_hi) begin
            valid = 1'b1;
            idx = lowest(hi_req);
            pick_lvl = 1'b1;
        end else if ((|lo_req) && !active_hi && !active_lo) begin
            valid = 1'b1;
            idx = lowest(lo_req);
        end
    end

endmodule : irq_prio_pick

`default_nettype wire

// >>> sim/core_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Core sequencer: ends instructions, takes calls
module core_model (
    input wire logic core_clk,
    input wire logic call_req,
    output logic insn_done,
    output logic return_from_interrupt_done,
    output logic call_ack
);
    initial begin
        insn_done = 1'b0;
        return_from_interrupt_done = 1'b0;
    end

    // Call taken only where an ordinary instruction ends
    assign call_ack = insn_done & call_req;

    // One instruction of len clocks, started at a falling edge
    task automatic exec(input int len, input logic is_return_from_interrupt);
        repeat (len - 1) @(negedge core_clk);
        if (is_return_from_interrupt) begin
            return_from_interrupt_done = 1'b1;
        end else begin
            insn_done = 1'b1;
        end
        @(negedge core_clk);
        insn_done = 1'b0;
        return_from_interrupt_done = 1'b0;
    endtask : exec
endmodule : core_model

`default_nettype wire

// >>> sim/two_level_vectored_irq_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none

module two_level_vectored_irq_unit_bench;
    logic core_clk, rst_b, sfr_wr, sfr_bit_wr, sfr_bit_val;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] sfr_bit_sel;
    logic ext_irq_pin_zero_n, ext_irq_pin_one_n;
    logic [1:0] ext_flag_sw_set, ext_flag_sw_clr, ext_flag;
    logic timer_zero_flag, timer_one_flag, timer_zero_clr, timer_one_clr;
    logic uart_rx_flag, uart_tx_flag;
    logic timer_two_low_overflow, timer_two_high_overflow;
    logic [3:0] serial_periph_flags;
    logic [9:0] ext_src_flags, ext_src_enable, ext_src_level;
    logic insn_done, return_from_interrupt_done, call_ack, call_req, call_level;
    logic [15:0] call_vector;
    logic [4:0] call_index;
    int failures = 0;
    int checks = 0;

    two_level_vectored_irq_unit DUT (
        .core_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr,
        .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .ext_irq_pin_zero_n,
        .ext_irq_pin_one_n, .ext_flag_sw_set, .ext_flag_sw_clr, .ext_flag,
        .timer_zero_flag, .timer_one_flag, .timer_zero_clr, .timer_one_clr,
        .uart_rx_flag, .uart_tx_flag, .timer_two_low_overflow,
        .timer_two_high_overflow, .serial_periph_flags, .ext_src_flags,
        .ext_src_enable, .ext_src_level, .insn_done, .return_from_interrupt_done, .call_ack,
        .call_req, .call_vector, .call_level, .call_index
    );
    core_model core (.core_clk, .call_req, .insn_done, .return_from_interrupt_done,
        .call_ack);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ==========================================================
    // Access and compare tasks
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        cyc(1);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic bwr(input logic [7:0] a, input int b, input logic v);
        sfr_addr = a;
        sfr_bit_sel = 3'(b);
        sfr_bit_val = v;
        sfr_bit_wr = 1'b1;
        cyc(1);
        sfr_bit_wr = 1'b0;
    endtask : bwr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        cyc(1);
        chk(16'(sfr_rdata), 16'(exp));
    endtask : rdchk

    // Raise or drop the pending condition of source i
    task automatic src(input int i, input logic v);
        case (i)
            0, 2: begin
                if (v) ext_flag_sw_set[i/2] = 1'b1;
                else ext_flag_sw_clr[i/2] = 1'b1;
            end
            1: timer_zero_flag = v;
            3: timer_one_flag = v;
            4: uart_tx_flag = v;
            5: timer_two_low_overflow = v;
            6: serial_periph_flags[3] = v;
            default: ext_src_flags[i-7] = v;
        endcase
        cyc(1);
        ext_flag_sw_set = 2'b00;
        ext_flag_sw_clr = 2'b00;
        cyc(1);
    endtask : src

    initial begin
        #20000;
        failures++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {rst_b, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_addr} = '0;
        {sfr_wdata, sfr_bit_sel, ext_flag_sw_set, ext_flag_sw_clr} = '0;
        {ext_irq_pin_zero_n, ext_irq_pin_one_n} = 2'b11;
        {timer_zero_flag, timer_one_flag, uart_rx_flag, uart_tx_flag} = '0;
        {timer_two_low_overflow, timer_two_high_overflow} = 2'b00;
        {serial_periph_flags, ext_src_flags, ext_src_level} = '0;
        ext_src_enable = '0;
        cyc(16);
        chk(call_vector, 16'h0000);
        rst_b = 1'b1;
        cyc(1);
        rdchk(8'ha8, 8'h00);
        rdchk(8'hb8, 8'h80);
        rdchk(8'h55, 8'h00);
        wr(8'hb8, 8'h55);
        rdchk(8'hb8, 8'hd5);
        wr(8'hb8, 8'h00);
        rdchk(8'hb8, 8'h80);
        wr(8'ha8, 8'h7f);
        src(1, 1'b1);
        chk(16'(call_req), 16'h0);
        bwr(8'ha8, 7, 1'b1);
        cyc(1);
        chk(16'(call_req), 16'h1);
        rdchk(8'ha8, 8'hff);
        src(1, 1'b0);
        {ext_src_enable, ext_src_level} = '1;
        for (int i = 0; i < 17; i++) begin
            src(i, 1'b1);
            chk(call_vector, 16'h0003 + 16'(8 * i));
            chk(16'(call_index), 16'(i));
            chk(16'(call_level), 16'(i > 6));
            if (i < 7) bwr(8'ha8, i, 1'b0);
            else ext_src_enable[i-7] = 1'b0;
            cyc(1);
            chk(16'(call_req), 16'h0);
            if (i < 7) bwr(8'ha8, i, 1'b1);
            else ext_src_enable[i-7] = 1'b1;
            src(i, 1'b0);
            chk(16'(call_req), 16'h0);
        end
        timer_two_high_overflow = 1'b1;
        cyc(1);
        chk(16'(call_index), 16'd5);
        timer_two_high_overflow = 1'b0;
        src(1, 1'b1);
        uart_rx_flag = 1'b1;
        cyc(1);
        chk(16'(call_index), 16'd1);
        bwr(8'hb8, 4, 1'b1);
        cyc(1);
        chk({call_level, 10'h0, call_index}, 16'h8004);
        core.exec(1, 1'b0);
        chk({timer_zero_clr, call_req}, 16'h0);
        core.exec(5, 1'b1);
        cyc(1);
        chk({call_req, call_index}, 16'h24);
        core.exec(8, 1'b0);
        chk(16'(call_req), 16'h0);
        uart_rx_flag = 1'b0;
        core.exec(5, 1'b1);
        cyc(1);
        chk({call_req, call_index}, 16'h21);
        core.exec(1, 1'b0);
        chk(16'(timer_zero_clr), 16'h1);
        src(1, 1'b0);
        chk(16'(timer_zero_clr), 16'h0);
        src(3, 1'b1);
        chk(16'(call_req), 16'h0);
        bwr(8'hb8, 2, 1'b1);
        src(2, 1'b1);
        chk({call_req, call_index}, 16'h22);
        core.exec(1, 1'b0);
        cyc(1);
        chk(16'(ext_flag), 16'h0);
        src(3, 1'b0);
        core.exec(5, 1'b1);
        core.exec(5, 1'b1);
        ext_irq_pin_zero_n = 1'b0;
        for (int k = 0; k < 8 && call_req !== 1'b1; k++) cyc(1);
        chk({call_req, call_index}, 16'h20);
        core.exec(1, 1'b0);
        cyc(1);
        chk(16'(ext_flag), 16'h0);
        ext_irq_pin_zero_n = 1'b1;
        cyc(4);
        core.exec(5, 1'b1);
        timer_one_flag = 1'b1;
        cyc(1);
        chk({call_req, call_index}, 16'h23);
        core.exec(1, 1'b0);
        chk({timer_one_clr, timer_zero_clr}, 16'h2);
        src(3, 1'b0);
        chk(16'(timer_one_clr), 16'h0);
        bwr(8'ha8, 2, 1'b0);
        ext_irq_pin_one_n = 1'b0;
        cyc(5);
        chk({call_req, ext_flag}, 16'h2);
        bwr(8'ha8, 2, 1'b1);
        cyc(1);
        chk({call_req, call_level, call_index}, 16'h62);
        core.exec(1, 1'b0);
        cyc(1);
        chk(16'(ext_flag), 16'h0);
        ext_irq_pin_one_n = 1'b1;
        cyc(4);
        end_of_test();
    end
endmodule : two_level_vectored_irq_unit_bench

`default_nettype wire
